// [isra_pkg.sv]
// shared constants and types for the serial register-access slave
package isra_pkg;

    // 7-bit slave address 1101000
    localparam logic [6:0] DEV_ADDR_RESET = 7'h68;
    // direction bit value that selects a read
    localparam logic       DIR_READ       = 1'b1;
    // bits per byte on the wire
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    // register pointer value after reset
    localparam logic [7:0] PTR_RESET      = 8'h00;
    // bench period of the serial clock, and samples per period at 8 ns
    localparam int         LINK_PERIOD_NS = 125;
    localparam int         CLK_PERIOD_NS  = 8;
    localparam int         LINK_SAMPLES   = LINK_PERIOD_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic scl;
        logic sda;
    } isra_pin_in_type;

    typedef struct packed {
        logic       strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } isra_wr_type;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } isra_state_type;

endpackage

// [isra_i2c_slave.sv]
// serial slave giving an outside bus master access to the register space
// How it works
// - read: ack address, then send data bytes
// - stop or repeated start ends a transfer
// - bytes travel most significant bit first
// - device acks every byte it receives except a non-matching address
// - start begins a transfer, stop ends it
// - first byte: address 1101000 plus direction
// - matching address gets data line pulled low
// - write: byte after address loads pointer
// - pointer advances after every data byte
// - direction one: device drives data line
// - first read byte from current pointer
// - read without pointer write uses last pointer
// - read goes on until master not-acknowledges
// - send bits in step with serial clock
// - after not-acknowledge, release data line high
// - data changes with clock high mean start/stop
`timescale 1ns/1ps

module isra_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = isra_pkg::DEV_ADDR_RESET
) (
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    input  wire isra_pkg::isra_pin_in_type pins,
    output logic                           sda_out,
    output logic                           sda_oe_n,
    output isra_pkg::isra_wr_type          wr,
    output logic [7:0]                     rd_addr,
    output logic                           rd_take,
    input  wire logic [7:0]                rd_data,
    output logic                           busy
);

    isra_pkg::isra_pin_in_type sync1_q;
    isra_pkg::isra_pin_in_type sync2_q;
    isra_pkg::isra_pin_in_type prev_q;
    isra_pkg::isra_state_type  state_q;
    logic [3:0]                bit_q;
    logic [7:0]                rx_q;
    logic [7:0]                tx_q;
    logic [7:0]                ptr_q;
    logic                      nack_q;
    logic                      start_ev;
    logic                      stop_ev;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      byte_end;
    logic                      addr_match;
    logic                      read_more;
    logic                      drive_d;
    logic                      in_byte;
    logic                      load_tx;

    // two-stage synchronisers; only stage two and later are read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q  <= '1;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // data edge with clock high is a bus condition
    assign start_ev   = sync2_q.scl && prev_q.scl && prev_q.sda && !sync2_q.sda;
    assign stop_ev    = sync2_q.scl && prev_q.scl && !prev_q.sda && sync2_q.sda;
    assign scl_rise   = sync2_q.scl && !prev_q.scl;
    assign scl_fall   = !sync2_q.scl && prev_q.scl;
    assign byte_end   = scl_fall && (bit_q == isra_pkg::BYTE_BITS);
    assign addr_match = (rx_q[7:1] == DEV_ADDR);
    assign read_more  = scl_fall && (state_q == isra_pkg::ST_RDATA_ACK) && !nack_q;
    assign in_byte    = (state_q == isra_pkg::ST_ADDR) || (state_q == isra_pkg::ST_PTR)
                        || (state_q == isra_pkg::ST_WDATA) || (state_q == isra_pkg::ST_RDATA);
    assign load_tx    = scl_fall
                        && ((state_q == isra_pkg::ST_ADDR_ACK && rx_q[0] == isra_pkg::DIR_READ)
                            || read_more);

    // transfer sequencing
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= isra_pkg::ST_IDLE;
        end else if (start_ev) begin
            // repeated start restarts at once, bus stays claimed
            state_q <= isra_pkg::ST_ADDR;
        end else if (stop_ev) begin
            state_q <= isra_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                isra_pkg::ST_IDLE,
                isra_pkg::ST_IGNORE: begin
                    state_q <= state_q;
                end
                isra_pkg::ST_ADDR: begin
                    if (byte_end) begin
                        if (addr_match) begin
                            state_q <= isra_pkg::ST_ADDR_ACK;
                        end else begin
                            state_q <= isra_pkg::ST_IGNORE;
                        end
                    end
                end
                isra_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rx_q[0] == isra_pkg::DIR_READ) begin
                            state_q <= isra_pkg::ST_RDATA;
                        end else begin
                            state_q <= isra_pkg::ST_PTR;
                        end
                    end
                end
                isra_pkg::ST_PTR: begin
                    if (byte_end) begin
                        state_q <= isra_pkg::ST_PTR_ACK;
                    end
                end
                isra_pkg::ST_PTR_ACK,
                isra_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_q <= isra_pkg::ST_WDATA;
                    end
                end
                isra_pkg::ST_WDATA: begin
                    if (byte_end) begin
                        state_q <= isra_pkg::ST_WDATA_ACK;
                    end
                end
                isra_pkg::ST_RDATA: begin
                    if (byte_end) begin
                        state_q <= isra_pkg::ST_RDATA_ACK;
                    end
                end
                isra_pkg::ST_RDATA_ACK: begin
                    if (scl_fall) begin
                        if (!nack_q) begin
                            state_q <= isra_pkg::ST_RDATA;
                        end else begin
                            state_q <= isra_pkg::ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    // bit counter within a byte; a cut byte is dropped
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bit_q <= '0;
        end else if (start_ev || stop_ev || byte_end) begin
            bit_q <= '0;
        end else if (scl_rise && in_byte) begin
            bit_q <= bit_q + 4'h1;
        end
    end

    // receive shift register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_q <= '0;
        end else if (!start_ev && !stop_ev && scl_rise && in_byte
                     && state_q != isra_pkg::ST_RDATA) begin
            rx_q <= {rx_q[6:0], sync2_q.sda};
        end
    end

    // transmit shift register, loaded at the fall that ends an ack slot
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_q <= '1;
        end else if (!start_ev && !stop_ev) begin
            if (load_tx) begin
                tx_q <= rd_data;
            end else if (scl_fall && !byte_end && state_q == isra_pkg::ST_RDATA) begin
                tx_q <= {tx_q[6:0], 1'b1};
            end
        end
    end

    // master acknowledge after each sent byte
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            nack_q <= 1'b1;
        end else if (!start_ev && !stop_ev && scl_rise
                     && state_q == isra_pkg::ST_RDATA_ACK) begin
            nack_q <= sync2_q.sda;
        end
    end

    // register pointer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ptr_q <= isra_pkg::PTR_RESET;
        end else if (!start_ev && !stop_ev && byte_end) begin
            if (state_q == isra_pkg::ST_PTR) begin
                ptr_q <= rx_q;
            end else if (state_q == isra_pkg::ST_WDATA || state_q == isra_pkg::ST_RDATA) begin
                ptr_q <= ptr_q + 8'h01;
            end
        end
    end

    // write strobe toward the register space, one cycle per data byte
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr <= '0;
        end else begin
            wr.strobe <= !start_ev && !stop_ev && byte_end && (state_q == isra_pkg::ST_WDATA);
            if (!start_ev && !stop_ev && byte_end && (state_q == isra_pkg::ST_WDATA)) begin
                wr.addr <= ptr_q;
                wr.data <= rx_q;
            end
        end
    end

    // read take pulse marks each byte loaded for sending
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_take <= 1'b0;
        end else begin
            rd_take <= !start_ev && !stop_ev && load_tx;
        end
    end

    // open-drain data pin: only ever pulls low
    always_comb begin
        unique case (state_q)
            isra_pkg::ST_ADDR_ACK,
            isra_pkg::ST_PTR_ACK,
            isra_pkg::ST_WDATA_ACK: drive_d = 1'b1;
            isra_pkg::ST_RDATA:     drive_d = !tx_q[7];
            default:                drive_d = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sda_out  <= 1'b0;
            sda_oe_n <= 1'b1;
            rd_addr  <= isra_pkg::PTR_RESET;
            busy     <= 1'b0;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= !drive_d || start_ev || stop_ev;
            rd_addr  <= ptr_q;
            busy     <= (state_q != isra_pkg::ST_IDLE);
        end
    end

endmodule

// [isra_i2c_slave_asserts.sv]
// port checks for the serial register-access slave
`timescale 1ns/1ps
module isra_i2c_slave_asserts (
    input wire logic                      ref_clk,
    input wire logic                      nrst,
    input wire isra_pkg::isra_pin_in_type pins,
    input wire logic                      sda_out,
    input wire logic                      sda_oe_n,
    input wire isra_pkg::isra_wr_type     wr,
    input wire logic [7:0]                rd_addr,
    input wire logic                      rd_take,
    input wire logic [7:0]                rd_data,
    input wire logic                      busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_pull_only_low: assert property (sda_out == 1'b0) else $error("sda_out high");
    chk_start_busy: assert property ($fell(pins.sda) && pins.scl |-> ##[1:6] busy)
        else $error("start not seen");
    chk_stop_idle: assert property ($rose(pins.sda) && pins.scl |-> ##[1:6] !busy)
        else $error("stop not seen");
    chk_idle_released: assert property (!busy [*3] |-> sda_oe_n)
        else $error("drive while idle");
    chk_strobe_single: assert property (wr.strobe |=> !wr.strobe) else $error("long strobe");
    chk_strobe_framed: assert property (wr.strobe |-> busy && !pins.scl)
        else $error("strobe outside byte end");
    chk_write_hold: assert property (!wr.strobe |-> $stable(wr.addr) && $stable(wr.data))
        else $error("write bus moved");
    chk_take_spacing: assert property (rd_take |=> !rd_take [*8])
        else $error("takes too close");
    chk_drive_scl_low: assert property ($changed(sda_oe_n) |-> !pins.scl)
        else $error("drive change with clock high");
    cover property (wr.strobe);
    cover property (rd_take);
    cover property (!sda_oe_n);
endmodule

bind isra_i2c_slave isra_i2c_slave_asserts chk (.ref_clk(ref_clk), .nrst(nrst), .pins(pins),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr(wr), .rd_addr(rd_addr), .rd_take(rd_take),
    .rd_data(rd_data), .busy(busy));

// [isra_master_model.sv]
// bus master model: makes the serial clock, start, stop and data bits
`timescale 1ns/1ps
module isra_master_model (
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        #31 scl = 1'b1;
        #31 r = sda_in;
        #32 scl = 1'b0;
        #31;
    endtask
    task automatic start();
        sda_m = 1'b1;
        #31 scl = 1'b1;
        #31 sda_m = 1'b0;
        #31 scl = 1'b0;
        #32;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #31 scl = 1'b1;
        #31 sda_m = 1'b1;
        #63;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic recv(input logic last, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
        bit_io(last, r);
    endtask
endmodule

// [tb_top.sv]
// self-checking bench for the serial register-access slave
`timescale 1ns/1ps
module tb_top;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
    logic                  ref_clk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  scl, sda_m, sda_oe_n, sda_out, rd_take, busy, r;
    logic [7:0]            rd_addr, ptr, b;
    logic [7:0]            mem [256];
    logic [7:0]            exp_mem [256];
    isra_pkg::isra_wr_type wr;
    wire                   sda = sda_m & (sda_oe_n | sda_out);
    int                    failures = 0, total_checks = 0, n_strobe = 0, n_exp = 0;
    int                    n_take = 0, n_rd = 0;
    isra_i2c_slave dut (.ref_clk(ref_clk), .nrst(nrst), .pins({scl, sda}), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .wr(wr), .rd_addr(rd_addr), .rd_take(rd_take),
        .rd_data(mem[rd_addr]), .busy(busy));
    isra_master_model m (.sda_in(sda), .scl(scl), .sda_m(sda_m));
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (wr.strobe) begin
            mem[wr.addr] <= wr.data;
            n_strobe <= n_strobe + 1;
        end
        if (rd_take) begin
            n_take <= n_take + 1;
        end
    end
    task automatic wrap_up();
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic end_xfer();
        m.stop();
        @(negedge ref_clk);
        `CHK(busy, 1'b0)
        `CHK(rd_addr, ptr)
    endtask
    task automatic do_write(input logic [7:0] a, input int n);
        m.start();
        m.send({isra_pkg::DEV_ADDR_RESET, 1'b0}, r);
        `CHK(r, 1'b0)
        m.send(a, r);
        `CHK(r, 1'b0)
        ptr = a;
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            m.send(b, r);
            `CHK(r, 1'b0)
            exp_mem[ptr] = b;
            ptr++;
            n_exp++;
        end
    endtask
    task automatic do_read(input int n);
        logic [7:0] q;
        m.start();
        m.send({isra_pkg::DEV_ADDR_RESET, isra_pkg::DIR_READ}, r);
        `CHK(r, 1'b0)
        for (int i = 1; i <= n; i++) begin
            m.recv(i == n, q);
            `CHK(q, exp_mem[ptr])
            ptr++;
            n_rd++;
        end
        #50;
        @(negedge ref_clk);
        `CHK(sda, 1'b1)
    endtask
    initial begin
        repeat (50000) @(posedge ref_clk);
        failures++;
        wrap_up();
    end
    initial begin
        void'($urandom(51102));
        for (int i = 0; i < 256; i++) begin
            b = 8'($urandom);
            mem[i] = b;
            exp_mem[i] = b;
        end
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) nrst = 1'b1;
        ptr = isra_pkg::PTR_RESET;
        do_read(2);
        end_xfer();
        do_write(8'hfe, 3);
        end_xfer();
        do_write(8'($urandom), 0);
        do_read(3);
        end_xfer();
        for (int d = 0; d < 2; d++) begin
            b = 8'($urandom_range(1, 127));
            m.start();
            m.send({isra_pkg::DEV_ADDR_RESET ^ b[6:0], d[0]}, r);
            `CHK(r, 1'b1)
            m.send(8'h00, r);
            `CHK(r, 1'b1)
            end_xfer();
        end
        repeat (6) begin
            do_write(8'($urandom), $urandom_range(1, 4));
            end_xfer();
            do_read($urandom_range(1, 4));
            end_xfer();
        end
        `CHK(n_strobe, n_exp)
        `CHK(n_take, n_rd)
        for (int i = 0; i < 256; i++) `CHK(mem[i], exp_mem[i])
        wrap_up();
    end
endmodule
